// [pp_pkg.sv]
package pp_pkg;

	// Timer field width and one timebase tick
	localparam int PP_TIME_W         = 16;
	localparam int PP_CLK_PERIOD_PS  = 4000;
	localparam int PP_TICK_PERIOD_US = 1000;
	localparam int PP_TICK_CYCLES    =
		(PP_TICK_PERIOD_US * 1000000) / PP_CLK_PERIOD_PS;
	localparam int PP_TICK_CNT_W     = 32;

	// Every delay and duration is a count of timebase ticks
	typedef struct packed {
		logic [PP_TIME_W-1:0] receive_qualify_delay;
		logic [PP_TIME_W-1:0] ground_pass_window;
		logic [PP_TIME_W-1:0] ground_block_window;
		logic [PP_TIME_W-1:0] operate_hold_time;
		logic [PP_TIME_W-1:0] echo_duration;
		logic [PP_TIME_W-1:0] echo_lockout;
		logic [PP_TIME_W-1:0] line_end_open_delay;
	} pp_settings_t;

	typedef struct packed {
		logic rx_qualified;
		logic line_end_open_valid;
		logic ground_path_open;
		logic ground_path_blocked;
		logic echo_active;
		logic echo_locked;
	} pp_status_t;

	localparam pp_status_t PP_STATUS_RESET = '0;
	localparam logic [PP_TIME_W-1:0] PP_TIME_ZERO = '0;
	localparam logic [PP_TIME_W-1:0] PP_TIME_ONE  = 16'h0001;

	typedef enum logic [1:0] {
		PP_TB_IDLE,
		PP_TB_PASS,
		PP_TB_BLOCK
	} pp_tb_state_t;

	typedef enum logic [1:0] {
		PP_ECHO_IDLE,
		PP_ECHO_SEND,
		PP_ECHO_LOCK
	} pp_echo_state_t;

endpackage

// [pp_pickup_timer.sv]
`timescale 1ns/1ps
// Output rises once the input has stood high for the set number of ticks;
// any drop of the input restarts the count and clears the output at once.
module pp_pickup_timer
	import pp_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 tick,
	input  wire logic                 level_in,
	input  wire logic [PP_TIME_W-1:0] delay,
	output logic                      qualified
);

	logic [PP_TIME_W-1:0] cnt_r;
	logic [PP_TIME_W-1:0] cnt_nxt;
	logic                 done;

	assign done    = (cnt_r >= delay);
	assign cnt_nxt = (tick && !done) ? cnt_r + PP_TIME_ONE : cnt_r;

	always_ff @(posedge clk) begin
		if (rst || !level_in) begin
			cnt_r     <= PP_TIME_ZERO;
			qualified <= 1'b0;
		end else begin
			cnt_r     <= cnt_nxt;
			qualified <= done;
		end
	end

endmodule

// [pp_pilot_logic.sv]
`timescale 1ns/1ps
module pp_pilot_logic
	import pp_pkg::*;
#(
	parameter int TICK_CYCLES = PP_TICK_CYCLES
)
(
	input  wire logic         CORE_CLK,
	input  wire logic         RESET,
	input  wire logic         ZONE2_PICKUP,
	input  wire logic         GROUND_ASSIGNED,
	input  wire logic         GROUND_FORWARD_INDICATION,
	input  wire logic         REMOTE_PERMISSION_IN,
	input  wire logic         LINE_END_OPEN_RAW,
	input  wire logic         ECHO_ENABLE,
	input  wire pp_settings_t SETTINGS,
	output logic              LOCAL_PERMISSION_OUT,
	output logic              PILOT_OPERATE_OUT,
	output pp_status_t        STATUS
);

	// Timebase divider
	logic [PP_TICK_CNT_W-1:0] tick_cnt_r;
	logic                     tick_r;
	logic                     tick_wrap;

	assign tick_wrap = (tick_cnt_r >= PP_TICK_CNT_W'(TICK_CYCLES - 1));

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else begin
			tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + 32'h00000001;
			tick_r     <= tick_wrap;
		end
	end

	// Qualifiers for receive and line-end-open
	logic rx_qual;
	logic leo_valid;

	pp_pickup_timer u_rx_qual (
		.clk       (CORE_CLK),
		.rst       (RESET),
		.tick      (tick_r),
		.level_in  (REMOTE_PERMISSION_IN),
		.delay     (SETTINGS.receive_qualify_delay),
		.qualified (rx_qual)
	);

	pp_pickup_timer u_leo_qual (
		.clk       (CORE_CLK),
		.rst       (RESET),
		.tick      (tick_r),
		.level_in  (LINE_END_OPEN_RAW),
		.delay     (SETTINGS.line_end_open_delay),
		.qualified (leo_valid)
	);

	// Keying
	logic ground_fwd;
	logic echo_send;
	logic tx_nxt;
	logic tx_rise;

	assign ground_fwd = GROUND_ASSIGNED && GROUND_FORWARD_INDICATION;
	assign tx_nxt     = ZONE2_PICKUP || ground_fwd || echo_send;
	assign tx_rise    = tx_nxt && !LOCAL_PERMISSION_OUT;

	// Transient blocking of the ground path
	pp_tb_state_t         tb_state_r;
	pp_tb_state_t         tb_state_nxt;
	logic [PP_TIME_W-1:0] tb_cnt_r;
	logic [PP_TIME_W-1:0] tb_cnt_nxt;
	logic                 tb_pass_done;
	logic                 tb_block_done;

	assign tb_pass_done  = (tb_cnt_r >= SETTINGS.ground_pass_window);
	assign tb_block_done = (tb_cnt_r >= SETTINGS.ground_block_window);

	always_comb begin
		tb_state_nxt = tb_state_r;
		tb_cnt_nxt   = tick_r ? tb_cnt_r + PP_TIME_ONE : tb_cnt_r;
		case (tb_state_r)
			PP_TB_IDLE: begin
				tb_cnt_nxt = PP_TIME_ZERO;
				if (tx_rise) begin
					tb_state_nxt = PP_TB_PASS;
				end
			end
			PP_TB_PASS: begin
				if (tb_pass_done) begin
					tb_state_nxt = PP_TB_BLOCK;
					tb_cnt_nxt   = PP_TIME_ZERO;
				end
			end
			PP_TB_BLOCK: begin
				if (tb_block_done) begin
					tb_state_nxt = PP_TB_IDLE;
					tb_cnt_nxt   = PP_TIME_ZERO;
				end
			end
			default: begin
				tb_state_nxt = PP_TB_IDLE;
				tb_cnt_nxt   = PP_TIME_ZERO;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			tb_state_r <= PP_TB_IDLE;
			tb_cnt_r   <= PP_TIME_ZERO;
		end else begin
			tb_state_r <= tb_state_nxt;
			tb_cnt_r   <= tb_cnt_nxt;
		end
	end

	// Operate decision; zone-2 needs no shaping since its reach is short
	logic ground_path_open;
	logic ground_term;
	logic op_cond;

	assign ground_path_open = (tb_state_r == PP_TB_PASS);
	assign ground_term      = ground_fwd && ground_path_open;
	assign op_cond          = rx_qual && (ZONE2_PICKUP || ground_term);

	// Seal-in: the hold counts from the last cycle the condition stood
	logic [PP_TIME_W-1:0] hold_cnt_r;
	logic [PP_TIME_W-1:0] hold_cnt_nxt;
	logic                 hold_done;
	logic                 op_nxt;

	assign hold_done    = (hold_cnt_r >= SETTINGS.operate_hold_time);
	assign hold_cnt_nxt = op_cond ? PP_TIME_ZERO :
		((tick_r && !hold_done) ? hold_cnt_r + PP_TIME_ONE : hold_cnt_r);
	assign op_nxt       = op_cond || (PILOT_OPERATE_OUT && !hold_done);

	// Echo one-shot; pulse and lockout each run from a fresh count
	pp_echo_state_t       echo_state_r;
	pp_echo_state_t       echo_state_nxt;
	logic [PP_TIME_W-1:0] echo_cnt_r;
	logic [PP_TIME_W-1:0] echo_cnt_nxt;
	logic                 echo_trigger;

	assign echo_trigger = ECHO_ENABLE && rx_qual && leo_valid;
	assign echo_send    = (echo_state_r == PP_ECHO_SEND);

	// The pulse runs its own tick phase from its start, so its width does
	// not jitter with the shared divider; lockout keeps the shared tick
	logic [PP_TICK_CNT_W-1:0] echo_ph_r;
	logic                     echo_tick;
	logic [PP_TIME_W-1:0]     echo_cnt_inc;
	logic                     echo_done;

	assign echo_tick    = (echo_ph_r >= PP_TICK_CNT_W'(TICK_CYCLES - 1));
	assign echo_cnt_inc = echo_cnt_r + PP_TIME_ONE;
	assign echo_done    = (echo_cnt_r >= SETTINGS.echo_duration) ||
		(echo_tick && (echo_cnt_inc >= SETTINGS.echo_duration));

	always_ff @(posedge CORE_CLK) begin
		if (RESET || !echo_send || echo_tick) begin
			echo_ph_r <= '0;
		end else begin
			echo_ph_r <= echo_ph_r + 32'h00000001;
		end
	end

	always_comb begin
		echo_state_nxt = echo_state_r;
		echo_cnt_nxt   = tick_r ? echo_cnt_r + PP_TIME_ONE : echo_cnt_r;
		case (echo_state_r)
			PP_ECHO_IDLE: begin
				echo_cnt_nxt = PP_TIME_ZERO;
				if (echo_trigger) begin
					echo_state_nxt = PP_ECHO_SEND;
				end
			end
			PP_ECHO_SEND: begin
				// Ends on its own count only, not on the receive signal
				echo_cnt_nxt = echo_tick ? echo_cnt_inc : echo_cnt_r;
				if (echo_done) begin
					echo_state_nxt = PP_ECHO_LOCK;
					echo_cnt_nxt   = PP_TIME_ZERO;
				end
			end
			PP_ECHO_LOCK: begin
				// Triggers are ignored here, which breaks the echo loop
				if (echo_cnt_r >= SETTINGS.echo_lockout) begin
					echo_state_nxt = PP_ECHO_IDLE;
					echo_cnt_nxt   = PP_TIME_ZERO;
				end
			end
			default: begin
				echo_state_nxt = PP_ECHO_IDLE;
				echo_cnt_nxt   = PP_TIME_ZERO;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			echo_state_r <= PP_ECHO_IDLE;
			echo_cnt_r   <= PP_TIME_ZERO;
		end else begin
			echo_state_r <= echo_state_nxt;
			echo_cnt_r   <= echo_cnt_nxt;
		end
	end

	// Registered outputs
	pp_status_t status_nxt;

	always_comb begin
		status_nxt                     = PP_STATUS_RESET;
		status_nxt.rx_qualified        = rx_qual;
		status_nxt.line_end_open_valid = leo_valid;
		status_nxt.ground_path_open    = ground_path_open;
		status_nxt.ground_path_blocked = (tb_state_r == PP_TB_BLOCK);
		status_nxt.echo_active         = echo_send;
		status_nxt.echo_locked         = (echo_state_r == PP_ECHO_LOCK);
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			LOCAL_PERMISSION_OUT <= 1'b0;
			PILOT_OPERATE_OUT    <= 1'b0;
			hold_cnt_r           <= PP_TIME_ZERO;
			STATUS               <= PP_STATUS_RESET;
		end else begin
			LOCAL_PERMISSION_OUT <= tx_nxt;
			PILOT_OPERATE_OUT    <= op_nxt;
			hold_cnt_r           <= hold_cnt_nxt;
			STATUS               <= status_nxt;
		end
	end

endmodule

// [pp_pilot_logic_assertions.sv]
`timescale 1ns/1ps
module pp_chk
	import pp_pkg::*;
#(
	parameter int TICK_CYCLES = 4
)
(
	input wire logic         CORE_CLK,
	input wire logic         RESET,
	input wire logic         ZONE2_PICKUP,
	input wire logic         REMOTE_PERMISSION_IN,
	input wire pp_settings_t SETTINGS,
	input wire logic         LOCAL_PERMISSION_OUT,
	input wire logic         PILOT_OPERATE_OUT,
	input wire pp_status_t   STATUS
);
	int op_run_r;
	int ec_run_r;
	int hold_cyc;
	int ec_cyc;
	assign hold_cyc = SETTINGS.operate_hold_time * TICK_CYCLES;
	assign ec_cyc = SETTINGS.echo_duration * TICK_CYCLES;
	// Run lengths in clocks of operate and echo, for the timing checks
	always_ff @(posedge CORE_CLK) begin
		op_run_r <= (RESET || !PILOT_OPERATE_OUT) ? 0 : op_run_r + 1;
		ec_run_r <= (RESET || !STATUS.echo_active) ? 0 : ec_run_r + 1;
	end
	default clocking dc @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);
	property p_tx;
		!$past(RESET) && $past(ZONE2_PICKUP) |-> LOCAL_PERMISSION_OUT;
	endproperty
	a_tx: assert property (p_tx) else $error("no key");
	property p_op;
		$rose(PILOT_OPERATE_OUT) |-> STATUS.rx_qualified;
	endproperty
	a_op: assert property (p_op) else $error("op without rx");
	property p_rxq;
		$rose(STATUS.rx_qualified) |-> $past(REMOTE_PERMISSION_IN, 5);
	endproperty
	a_rxq: assert property (p_rxq) else $error("rx early");
	property p_rxd;
		$fell(REMOTE_PERMISSION_IN) |-> ##[0:2] !STATUS.rx_qualified;
	endproperty
	a_rxd: assert property (p_rxd) else $error("rx stuck");
	// One tick of slack: the hold starts at a free-running tick phase
	property p_hold;
		$fell(PILOT_OPERATE_OUT) |-> op_run_r + TICK_CYCLES >= hold_cyc;
	endproperty
	a_hold: assert property (p_hold) else $error("op short");
	property p_echo;
		$fell(STATUS.echo_active) |-> STATUS.echo_locked && ec_run_r == ec_cyc;
	endproperty
	a_echo: assert property (p_echo) else $error("echo");
	property p_gblk;
		$fell(STATUS.ground_path_open) |-> STATUS.ground_path_blocked[*8];
	endproperty
	a_gblk: assert property (p_gblk) else $error("no block");
	property p_rst;
		disable iff (1'h0) RESET |=> !PILOT_OPERATE_OUT &&
			!LOCAL_PERMISSION_OUT && STATUS == PP_STATUS_RESET;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
endmodule
bind pp_pilot_logic pp_chk #(.TICK_CYCLES(TICK_CYCLES)) u_pp_chk (
	.CORE_CLK(CORE_CLK), .RESET(RESET), .ZONE2_PICKUP(ZONE2_PICKUP),
	.REMOTE_PERMISSION_IN(REMOTE_PERMISSION_IN), .SETTINGS(SETTINGS),
	.LOCAL_PERMISSION_OUT(LOCAL_PERMISSION_OUT),
	.PILOT_OPERATE_OUT(PILOT_OPERATE_OUT), .STATUS(STATUS));

// [pp_remote_end.sv]
`timescale 1ns/1ps
// Far terminal as seen through the signalling channel
module pp_remote_end (
	input  wire logic       clk,
	input  wire logic       tx_in,
	input  wire logic       fault_fwd,
	input  wire logic       echo_back,
	input  wire logic [3:0] latency,
	output logic            rx_out
);
	logic [15:0] line_r;
	// Longer latency models a slow channel
	always_ff @(posedge clk) begin
		line_r <= {line_r[14:0], fault_fwd | (echo_back & tx_in)};
	end
	assign rx_out = line_r[latency];
endmodule

// [pp_tb.sv]
`timescale 1ns/1ps
module tb;
	import pp_pkg::*;
	localparam int TK = 4;
	logic         clk = 1'h0;
	logic         rst = 1'h1;
	logic         z2, ga, gf, rx, leo, ee, tx, op, ff;
	logic [3:0]   lat;
	pp_settings_t cfg;
	pp_status_t   st;
	int           failures = 0;
	int           compares = 0;
	int           n;
	always #2 clk = ~clk;
	pp_pilot_logic #(.TICK_CYCLES(TK)) u_pp_pilot_logic (.CORE_CLK(clk),
		.RESET(rst), .ZONE2_PICKUP(z2), .GROUND_ASSIGNED(ga),
		.GROUND_FORWARD_INDICATION(gf), .REMOTE_PERMISSION_IN(rx),
		.LINE_END_OPEN_RAW(leo), .ECHO_ENABLE(ee), .SETTINGS(cfg),
		.LOCAL_PERMISSION_OUT(tx), .PILOT_OPERATE_OUT(op), .STATUS(st));
	pp_remote_end u_pp_remote_end (.clk(clk), .tx_in(tx), .fault_fwd(ff),
		.echo_back(1'h0), .latency(lat), .rx_out(rx));
	task automatic chk(input logic got, input logic exp, input int id);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t check %0d got %b", $time, id, got);
		end
	endtask
	function automatic logic exp_key(input logic z, input logic a,
		input logic g);
		return z | (a & g);
	endfunction
	task automatic tally_and_finish();
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic tk(input int c);
		repeat (c) @(negedge clk);
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		chk(1'h0, 1'h1, 99);
		tally_and_finish();
	end
	initial begin
		{z2, ga, gf, leo, ee, ff} = '0;
		lat = 4'h1;
		cfg = {16'h0002, 16'h0004, 16'h0008, 16'h0003,
			16'h0002, 16'h0004, 16'h0002};
		n = $urandom(32757);
		tk(10);
		chk(st === PP_STATUS_RESET && !tx && !op, 1'h1, 0);
		rst = 1'h0;
		for (int i = 0; i < 12; i++) begin
			{z2, ga, gf} = (i < 8) ? i[2:0] : 3'($urandom);
			tk(2);
			chk(tx, exp_key(z2, ga, gf), 1);
		end
		{z2, ga, gf, ff} = 4'h9;
		lat = 4'($urandom_range(6, 1));
		for (n = 0; n < 40 && op !== 1'h1; n++) tk(1);
		chk(op, 1'h1, 2);
		{z2, ff} = 2'h0;
		tk(8);
		chk(op, 1'h1, 3);
		// Let the transient shaper fall back to idle before the next key
		tk(60);
		{ga, gf, ff, lat} = 7'h71;
		for (n = 0; n < 30 && op !== 1'h1; n++) tk(1);
		chk(op, 1'h1, 4);
		for (n = 0; n < 40 && st.ground_path_blocked !== 1'h1; n++) tk(1);
		tk(16);
		chk(op, 1'h0, 5);
		z2 = 1'h1;
		tk(4);
		chk(op, 1'h1, 6);
		{z2, ga, gf, leo} = 4'h1;
		tk(30);
		chk(tx, 1'h0, 7);
		chk(st.line_end_open_valid, 1'h1, 8);
		ee = 1'h1;
		for (n = 0; n < 20 && tx !== 1'h1; n++) tk(1);
		for (n = 0; n < 40 && tx === 1'h1; n++) tk(1);
		chk(n == 2 * TK, 1'h1, 9);
		for (n = 0; n < 12 && tx !== 1'h1; n++) tk(1);
		chk(n == 12, 1'h1, 10);
		for (n = 0; n < 30 && tx !== 1'h1; n++) tk(1);
		chk(tx, 1'h1, 11);
		tally_and_finish();
	end
endmodule
